// ---- src/adc_conversion_sequencer.v ----
// successive approximation sequencer with register port and triggers
//
// Our own choices: strobed register access and the address map.
`default_nettype none
`include "adc_seq_defs.vh"
module adc_conversion_sequencer #(
   parameter RES_BITS = 10,
   parameter BIT_CYC = `BIT_CYCLES
) (
   // clock and control
   input wire clk,
   input wire rst,
   input wire ce,
   // register port
   input wire [3:0] addr,
   input wire [7:0] wdata,
   input wire wr,
   input wire rd,
   output reg [7:0] rdata,
   // system state
   input wire sleep_exec,
   // analog comparator from the dac array
   input wire cmp_in,
   // trigger sources
   input wire timer0_wrap_pulse,
   input wire timer1_wrap_pulse,
   input wire timer2_period_match,
   input wire comparator_one_synced_out,
   input wire comparator_two_synced_out,
   input wire [3:0] pwm_offset_match,
   input wire [15:0] pwm_irq_events,
   input wire conversion_trigger_pin,
   input wire waveform_gen_input_pin,
   // outputs
   output reg analog_power,
   output reg [RES_BITS-1:0] dac_code,
   output reg wake_request,
   output reg conversion_done_flag
);
   // ==========================================
   // states
   localparam [1:0] ST_IDLE = 2'b01;
   localparam [1:0] ST_CONV = 2'b10;
   // counter end points; sliced where they meet narrower registers
   localparam integer TOP_IDX = RES_BITS - 1;
   localparam integer LAST_CYC = BIT_CYC - 1;

   // ==========================================
   // pin synchronisers
   // the comparator decision is two cycles old when a bit tick reads it
   reg [1:0] trig_pin_s_reg;
   reg [1:0] cwg_pin_s_reg;
   reg [1:0] cmp_s_reg;
   always @(posedge clk) begin
      if (rst) begin
         trig_pin_s_reg <= 2'b00;
         cwg_pin_s_reg <= 2'b00;
         cmp_s_reg <= 2'b00;
      end else if (ce) begin
         trig_pin_s_reg <= {trig_pin_s_reg[0], conversion_trigger_pin};
         cwg_pin_s_reg <= {cwg_pin_s_reg[0], waveform_gen_input_pin};
         cmp_s_reg <= {cmp_s_reg[0], cmp_in};
      end
   end

   // ==========================================
   // registers
   // software visible settings
   reg converter_enable;
   reg [3:0] trigger_select_field;
   reg rc_clk_sel_reg;
   reg irq_en_reg;
   reg pwm_irq_mode_reg;
   reg [3:0] pwm_irq_enable_reg [0:3];

   // sequencer state; powered_down_reg leaves the enable bit untouched in sleep
   reg [RES_BITS-1:0] result_reg;
   reg [1:0] state_reg;
   reg [RES_BITS-1:0] sar_reg;
   reg [3:0] bit_idx_reg;
   reg [7:0] cyc_reg;
   reg powered_down_reg;

   // pwm trigger: direct offset match or masked interrupts, per unit
   reg [3:0] pwm_trig;
   integer u;
   always @* begin
      pwm_trig = 4'h0;
      for (u = 0; u < 4; u = u + 1) begin
         pwm_trig[u] = pwm_irq_mode_reg ? |(pwm_irq_events[u*4 +: 4] & pwm_irq_enable_reg[u])
            : pwm_offset_match[u];
      end
   end

   // source order follows the select encoding
   wire [14:0] sources = {cwg_pin_s_reg[1], trig_pin_s_reg[1],
      pwm_trig[3], pwm_offset_match[3], pwm_trig[2], pwm_offset_match[2],
      pwm_trig[1], pwm_offset_match[1], pwm_trig[0], pwm_offset_match[0],
      comparator_two_synced_out, comparator_one_synced_out,
      timer2_period_match, timer1_wrap_pulse, timer0_wrap_pulse};
   wire trig_edge;
   trigger_select u_trig (
      .clk(clk),
      .rst(rst),
      .ce(ce),
      .sel(trigger_select_field),
      .sources(sources),
      .edge_pulse(trig_edge)
   );

   // fill unresolved low bits with the last resolved bit
   function [RES_BITS-1:0] fill_partial;
      input [RES_BITS-1:0] v;
      input [3:0] idx;
      integer k;
      begin
         fill_partial = v;
         if (idx < RES_BITS - 1) begin
            for (k = 0; k < RES_BITS; k = k + 1) begin
               if (k <= idx) fill_partial[k] = v[idx + 1];
            end
         end
      end
   endfunction

   // drop the trial bit when the input sits at or below the trial code
   function [RES_BITS-1:0] resolve_bit;
      input [RES_BITS-1:0] code;
      input [3:0] idx;
      input keep;
      begin
         resolve_bit = code;
         if (!keep) resolve_bit[idx] = 1'b0;
      end
   endfunction

   // ==========================================
   // decoded strobes
   // bus decode; go needs the enable bit in the same write, so a write that
   // disables cannot start a conversion on its way out
   wire wr_first = wr && addr == `OFS_CTRL_FIRST;
   wire go_write = wr_first && wdata[`BIT_GO] && wdata[`BIT_ENABLE];
   wire go_clear = wr_first && !wdata[`BIT_GO];
   wire flag_clr = wr && addr == `OFS_FLAGS && !wdata[`BIT_DONE_FLAG];

   // sequencer conditions
   wire busy = state_reg == ST_CONV;
   wire last_bit = bit_idx_reg == 4'h0;
   wire bit_tick = cyc_reg == LAST_CYC[7:0];
   wire usable = converter_enable && !powered_down_reg;
   wire sleep_abort = sleep_exec && !rc_clk_sel_reg;

   // events; done mirrors the last-bit branch of the sequencer exactly
   wire done_evt = busy && bit_tick && last_bit && converter_enable
      && !sleep_abort && !go_clear;
   wire start = !busy && usable && !sleep_abort && (go_write || trig_edge);

   // ==========================================
   // sequencer
   always @(posedge clk) begin
      if (rst) begin
         state_reg <= ST_IDLE;
         sar_reg <= {RES_BITS{1'b0}};
         bit_idx_reg <= 4'h0;
         cyc_reg <= 8'h00;
         result_reg <= {RES_BITS{1'b0}};
         dac_code <= {RES_BITS{1'b0}};
         conversion_done_flag <= 1'b0;
         wake_request <= 1'b0;
      end else if (ce) begin
         wake_request <= 1'b0;
         // set beats software clear
         if (done_evt)
            conversion_done_flag <= 1'b1;
         else if (flag_clr)
            conversion_done_flag <= 1'b0;
         case (state_reg)
            ST_IDLE: begin
               // a go write or a trigger edge starts from the top bit
               if (start) begin
                  state_reg <= ST_CONV;
                  bit_idx_reg <= TOP_IDX[3:0];
                  sar_reg <= {RES_BITS{1'b0}};
                  dac_code <= {1'b1, {(RES_BITS-1){1'b0}}};
                  cyc_reg <= 8'h00;
               end
            end
            ST_CONV: begin
               // aborts first, then one decision per bit tick
               if (sleep_abort || !converter_enable) begin
                  state_reg <= ST_IDLE;
               end else if (go_clear) begin
                  state_reg <= ST_IDLE;
                  result_reg <= fill_partial(sar_reg, bit_idx_reg);
               end else if (bit_tick) begin
                  cyc_reg <= 8'h00;
                  if (last_bit) begin
                     state_reg <= ST_IDLE;
                     result_reg <= resolve_bit(dac_code, bit_idx_reg, cmp_s_reg[1]);
                     if (sleep_exec && irq_en_reg)
                        wake_request <= 1'b1;
                  end else begin
                     sar_reg <= resolve_bit(dac_code, bit_idx_reg, cmp_s_reg[1]);
                     dac_code <= resolve_bit(dac_code, bit_idx_reg, cmp_s_reg[1])
                        | ({{(RES_BITS-1){1'b0}}, 1'b1} << (bit_idx_reg - 4'h1));
                     bit_idx_reg <= bit_idx_reg - 4'h1;
                  end
               end else begin
                  cyc_reg <= cyc_reg + 8'h01;
               end
            end
            default: state_reg <= ST_IDLE;
         endcase
      end
   end

   // ==========================================
   // sleep power-down; the enable bit keeps reading 1 throughout
   always @(posedge clk) begin
      if (rst) begin
         powered_down_reg <= 1'b0;
      end else if (ce) begin
         if (!converter_enable || !sleep_exec)
            powered_down_reg <= 1'b0;
         else if (sleep_abort)
            powered_down_reg <= 1'b1;
         else if (done_evt && !irq_en_reg)
            powered_down_reg <= 1'b1;
      end
   end

   // ==========================================
   // software registers
   integer p;
   always @(posedge clk) begin
      if (rst) begin
         converter_enable <= 1'b0;
         trigger_select_field <= 4'h0;
         rc_clk_sel_reg <= 1'b0;
         irq_en_reg <= 1'b0;
         pwm_irq_mode_reg <= 1'b0;
         for (p = 0; p < 4; p = p + 1) pwm_irq_enable_reg[p] <= 4'h0;
      end else if (ce && wr) begin
         // writes to read-only or unmapped offsets fall through harmlessly
         case (addr)
            `OFS_CTRL_FIRST: converter_enable <= wdata[`BIT_ENABLE];
            `OFS_CTRL_THIRD: trigger_select_field <= wdata[3:0];
            `OFS_SYS_CFG: begin
               rc_clk_sel_reg <= wdata[`BIT_RC_CLK];
               irq_en_reg <= wdata[`BIT_IRQ_EN];
               pwm_irq_mode_reg <= wdata[`BIT_PWM_IRQ_MODE];
            end
            `OFS_PWM_IRQ_EN: begin
               pwm_irq_enable_reg[wdata[5:4]] <= wdata[3:0];
            end
            default: begin
            end
         endcase
      end
   end

   // ==========================================
   // read data and power output, registered
   always @(posedge clk) begin
      if (rst) begin
         rdata <= 8'h00;
         analog_power <= 1'b0;
      end else if (ce) begin
         analog_power <= usable;
         // rdata falls back to zero unless a read was taken
         rdata <= 8'h00;
         if (rd) begin
            case (addr)
               `OFS_CTRL_FIRST: rdata <= {6'h00, busy, converter_enable};
               `OFS_CTRL_THIRD: rdata <= {4'h0, trigger_select_field};
               `OFS_RES_HIGH: rdata <= {6'h00, result_reg[9:8]};
               `OFS_RES_LOW: rdata <= result_reg[7:0];
               `OFS_FLAGS: rdata <= {6'h00, busy, conversion_done_flag};
               `OFS_SYS_CFG: rdata <= {5'h00, pwm_irq_mode_reg, irq_en_reg, rc_clk_sel_reg};
               default: rdata <= 8'h00;
            endcase
         end
      end
   end
endmodule
`default_nettype wire

// ---- src/adc_seq_defs.vh ----
// constants for the converter sequencer: offsets, fields, resets, timing
`ifndef ADC_SEQ_DEFS_VH
`define ADC_SEQ_DEFS_VH
// register offsets
`define OFS_CTRL_FIRST 4'h0
`define OFS_CTRL_THIRD 4'h1
`define OFS_RES_HIGH 4'h2
`define OFS_RES_LOW 4'h3
`define OFS_FLAGS 4'h4
`define OFS_PWM_IRQ_EN 4'h5
`define OFS_SYS_CFG 4'h6
// converter_control_first fields
`define BIT_ENABLE 0
`define BIT_GO 1
// flags register fields
`define BIT_DONE_FLAG 0
`define BIT_ACTIVE 1
// system config fields
`define BIT_RC_CLK 0
`define BIT_IRQ_EN 1
`define BIT_PWM_IRQ_MODE 2
// reset values
`define RST_CTRL_FIRST 8'h00
`define RST_CTRL_THIRD 8'h00
`define RST_SYS_CFG 8'h00
`define RST_PWM_IRQ_EN 8'h00
// timing: cycles per resolved bit
`define BIT_TIME_NS 16
`define CLK_PERIOD_NS 4
`define BIT_CYCLES (((`BIT_TIME_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`endif

// ---- src/trigger_select.v ----
// trigger source selector with rising edge detection
`default_nettype none
module trigger_select (
   // clock and control
   input wire clk,
   input wire rst,
   input wire ce,
   // selection
   input wire [3:0] sel,
   input wire [14:0] sources,
   // edge pulse
   output reg edge_pulse
);
   // ==========================================
   // selection and edge detect
   reg last_reg;
   // code 15 has no source behind it and reads as a quiet line
   wire [15:0] padded = {1'b0, sources};
   wire cur = padded[sel];
   // a select change can produce one spurious edge; accepted as harmless
   always @(posedge clk) begin
      if (rst) begin
         last_reg <= 1'b0;
         edge_pulse <= 1'b0;
      end else if (ce) begin
         last_reg <= cur;
         edge_pulse <= cur & ~last_reg;
      end
   end
endmodule
`default_nettype wire

// ---- dv/analog_src_model.sv ----
// analog source model feeding the sar comparator
`default_nettype none
module analog_src_model (
   // trial code and held input level
   input wire logic [9:0] dac_code,
   input wire logic [9:0] level,
   // decision, 1 = input above trial code
   output logic cmp_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // level only moves between conversions
   assign cmp_in = level > dac_code;
endmodule
`default_nettype wire

// ---- dv/adc_seq_asserts.sv ----
// port assertions for the conversion sequencer
`default_nettype none
module adc_seq_checker (
   // clock and reset
   input wire logic clk,
   input wire logic rst,
   // register port
   input wire logic [3:0] addr,
   input wire logic [7:0] wdata,
   input wire logic wr,
   input wire logic rd,
   input wire logic [7:0] rdata,
   // state and outputs
   input wire logic sleep_exec,
   input wire logic analog_power,
   input wire logic wake_request,
   input wire logic conversion_done_flag
);
   logic rc_reg;
   logic clr;
   // ==========================================
   // helper state
   // rc choice mirrored, sleep behaviour hangs on it
   always_ff @(posedge clk) begin
      if (rst) rc_reg <= 1'b0;
      else if (wr && addr == 4'h6) rc_reg <= wdata[0];
   end
   // software clear of the done flag
   assign clr = wr && addr == 4'h4 && !wdata[0];
   default clocking @(posedge clk); endclocking
   default disable iff (rst);
   // ==========================================
   // properties
   rst_zero_a: assert property (disable iff (1'b0) rst |=>
      !analog_power && !conversion_done_flag && !wake_request) else $error("reset state");
   rdata_idle_a: assert property (!rd |=> rdata == 8'h00) else $error("rdata idle");
   unmapped_rd_a: assert property (rd && addr > 4'h6 |=> rdata == 8'h00) else $error("unmapped");
   disable_off_a: assert property (wr && addr == 4'h0 && !wdata[0]
      |-> ##[1:2] !analog_power) else $error("power on");
   wake_flag_a: assert property (wake_request |-> ##[0:2] conversion_done_flag)
      else $error("wake no flag");
   wake_pulse_a: assert property (wake_request |=> !wake_request) else $error("wake long");
   flag_hold_a: assert property (conversion_done_flag && !clr |=> conversion_done_flag)
      else $error("flag lost");
   sleep_off_a: assert property (sleep_exec && !rc_reg && analog_power
      |-> ##[1:3] !analog_power) else $error("sleep power");
   cover property (wake_request);
   cover property ($rose(conversion_done_flag));
   cover property (sleep_exec && rc_reg && analog_power);
endmodule
bind adc_conversion_sequencer adc_seq_checker u_adc_seq_checker (.clk(clk), .rst(rst),
   .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .sleep_exec(sleep_exec),
   .analog_power(analog_power), .wake_request(wake_request),
   .conversion_done_flag(conversion_done_flag));
`default_nettype wire

// ---- dv/adc_conversion_sequencer_test.sv ----
// self-checking bench for the conversion sequencer
`default_nettype none
`define CHK(g, e) begin n_tests++; if ((g) !== (e)) begin mismatches++; \
   $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e); end end
module adc_conversion_sequencer_test;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk, rst, ce, wr, rd, sleep_exec, cmp_in, analog_power, wake_request;
   logic conversion_done_flag;
   logic [3:0] addr;
   logic [7:0] wdata, rdata, d;
   logic [14:0] src;
   logic [9:0] dac_code, level, res;
   integer mismatches = 0, n_tests = 0, seed = 32'h181004b5, i, k, wakes = 0;
   // ==========================================
   // device and far side
   adc_conversion_sequencer u_adc_conversion_sequencer (.clk(clk), .rst(rst), .ce(ce),
      .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
      .sleep_exec(sleep_exec), .cmp_in(cmp_in), .timer0_wrap_pulse(src[0]),
      .timer1_wrap_pulse(src[1]), .timer2_period_match(src[2]),
      .comparator_one_synced_out(src[3]), .comparator_two_synced_out(src[4]),
      .pwm_offset_match({src[11], src[9], src[7], src[5]}),
      .pwm_irq_events({3'h0, src[12], 3'h0, src[10], 3'h0, src[8], 3'h0, src[6]}),
      .conversion_trigger_pin(src[13]), .waveform_gen_input_pin(src[14]),
      .analog_power(analog_power), .dac_code(dac_code), .wake_request(wake_request),
      .conversion_done_flag(conversion_done_flag));
   analog_src_model u_analog_src_model (.dac_code(dac_code), .level(level), .cmp_in(cmp_in));
   // ==========================================
   // clock and wake counter
   initial begin
      clk = 1'b0;
      forever #2 clk = ~clk;
   end
   always @(posedge clk) if (wake_request === 1'b1) wakes++;
   // ==========================================
   // reference model and bus tasks
   // sar result with nb bits resolved, the rest copying the last one
   function automatic integer sar(input integer lv, input integer nb);
      integer c, b;
      c = 0;
      for (b = 9; b >= 10 - nb; b--) if (lv > (c | (1 << b))) c = c | (1 << b);
      if ((c >> (10 - nb)) & 1) c = c | ((1 << (10 - nb)) - 1);
      return c;
   endfunction
   task automatic wreg(input logic [3:0] a, input logic [7:0] v);
      @(posedge clk);
      wr <= 1'b1;
      addr <= a;
      wdata <= v;
      @(posedge clk);
      wr <= 1'b0;
   endtask
   task automatic rreg(input logic [3:0] a);
      @(posedge clk);
      rd <= 1'b1;
      addr <= a;
      @(posedge clk);
      rd <= 1'b0;
      #1 d = rdata;
   endtask
   task automatic get_res;
      rreg(4'h2);
      res[9:8] = d[1:0];
      rreg(4'h3);
      res[7:0] = d;
   endtask
   task automatic chk_res(input integer e);
      get_res;
      `CHK(res, e[9:0])
   endtask
   // bounded wait; running out ends the run
   task automatic wait_done;
      for (k = 0; k < 300 && conversion_done_flag !== 1'b1; k++) @(posedge clk);
      if (k >= 300) begin
         mismatches++;
         summarize;
      end
   endtask
   task automatic start(input logic [7:0] cfg);
      wreg(4'h6, cfg);
      level <= 10'($random(seed));
      repeat (4) @(posedge clk); // acquisition
      wreg(4'h0, 8'h03);
   endtask
   task automatic summarize;
      $display("checks %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // ==========================================
   // scenarios
   initial begin
      {ce, wr, rd, sleep_exec, addr, wdata, src, level} = '0;
      rst = 1'b1;
      ce = 1'b1;
      repeat (3) @(posedge clk);
      rst <= 1'b0;
      for (i = 0; i < 16; i++) begin
         rreg(i[3:0]);
         `CHK(d, 8'h00)
      end
      $display("test reset done");
      wreg(4'h0, 8'h01); // enable alone first
      for (i = 0; i < 4; i++) begin
         start(8'h00);
         rreg(4'h0);
         `CHK(d[1], 1'b1)
         rreg(4'h4);
         `CHK(d, 8'h02)
         if (i == 1) begin
            @(posedge clk);
            ce <= 1'b0; // freeze mid conversion
            @(posedge clk);
            res = dac_code;
            repeat (20) @(posedge clk);
            `CHK({conversion_done_flag, dac_code}, {1'b0, res})
            ce <= 1'b1;
         end
         wait_done;
         chk_res(sar(level, 10));
         rreg(4'h0);
         `CHK(d[1], 1'b0)
         wreg(4'h4, 8'h00);
      end
      $display("test software done");
      wreg(4'h0, 8'h00);
      wreg(4'h0, 8'h02);
      repeat (80) @(posedge clk);
      `CHK(conversion_done_flag, 1'b0)
      wreg(4'h0, 8'h01);
      start(8'h00);
      repeat (14) @(posedge clk);
      wreg(4'h0, 8'h01);
      chk_res(sar(level, 3)); // three bit ticks passed before the clear
      rreg(4'h0);
      `CHK({d[1], conversion_done_flag}, 2'b00)
      $display("test abort done");
      for (i = 0; i < 4; i++) wreg(4'h5, {2'h0, i[1:0], 4'hF});
      for (i = 0; i < 15; i++) begin
         wreg(4'h1, i[7:0]);
         rreg(4'h1);
         `CHK(d, i[7:0])
         level <= 10'($random(seed));
         wreg(4'h6, (i == 6 || i == 8 || i == 10 || i == 12) ? 8'h04 : 8'h00);
         src[i] <= 1'b1;
         repeat (3) @(posedge clk);
         src[i] <= 1'b0;
         wait_done;
         chk_res(sar(level, 10));
         wreg(4'h4, 8'h00);
      end
      wreg(4'h1, 8'h0F); // code 15 has no source
      src <= '1;
      repeat (10) @(posedge clk);
      rreg(4'h0);
      `CHK(d[1], 1'b0)
      src <= '0;
      $display("test triggers done");
      start(8'h00);
      sleep_exec <= 1'b1;
      repeat (80) @(posedge clk);
      `CHK({analog_power, conversion_done_flag}, 2'b00)
      rreg(4'h0);
      `CHK(d[0], 1'b1)
      sleep_exec <= 1'b0;
      start(8'h03);
      sleep_exec <= 1'b1;
      wait_done;
      repeat (3) @(posedge clk);
      `CHK(wakes, 1)
      chk_res(sar(level, 10));
      sleep_exec <= 1'b0;
      wreg(4'h4, 8'h00);
      start(8'h01);
      sleep_exec <= 1'b1;
      wait_done;
      repeat (3) @(posedge clk);
      `CHK(analog_power, 1'b0)
      rreg(4'h0);
      `CHK(d[0], 1'b1)
      sleep_exec <= 1'b0;
      $display("test sleep done");
      start(8'h00);
      repeat (6) @(posedge clk);
      rst <= 1'b1;
      @(posedge clk);
      rst <= 1'b0;
      rreg(4'h0);
      `CHK({d, analog_power}, 9'h000)
      $display("test mid reset done");
      summarize;
   end
endmodule
`default_nettype wire
